// ### logic/pmrs_conv_timer.sv
`timescale 1ns/1ps
module pmrs_conv_timer #(
   parameter int CYCLES_PER_US = pmrs_pkg::CYCLES_PER_US_DFLT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] conv_sel,
   input wire logic [2:0] avg_sel,
   output logic conv_tick,
   output logic cycle_done
);
   logic [pmrs_pkg::CONV_CNT_W-1:0] cyc_q, cyc_d;
   logic [pmrs_pkg::AVG_CNT_W-1:0] avg_q, avg_d;
   logic tick_q, tick_d;
   logic done_q, done_d;
   logic [pmrs_pkg::CONV_CNT_W-1:0] limit;
   logic [pmrs_pkg::AVG_CNT_W-1:0] navg;

   // Compare with >= so a shorter setting takes effect at once
   always_comb begin
      limit = pmrs_pkg::conv_cycles(conv_sel, CYCLES_PER_US);
      navg = pmrs_pkg::avg_count(avg_sel);
      cyc_d = cyc_q + 21'h000001;
      avg_d = avg_q;
      tick_d = 1'b0;
      done_d = 1'b0;
      if (cyc_q >= limit - 21'h000001) begin
         cyc_d = 21'h000000;
         tick_d = 1'b1;
         if (avg_q >= navg - 11'h001) begin
            avg_d = 11'h000;
            done_d = 1'b1;
         end else begin
            avg_d = avg_q + 11'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cyc_q <= 21'h000000;
         avg_q <= 11'h000;
         tick_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cyc_q <= cyc_d;
         avg_q <= avg_d;
         tick_q <= tick_d;
         done_q <= done_d;
      end
   end

   assign conv_tick = tick_q;
   assign cycle_done = done_q;

   // Helper counters for the checks below
   logic [pmrs_pkg::CONV_CNT_W-1:0] gap_q;
   logic [pmrs_pkg::AVG_CNT_W-1:0] ticks_q;
   logic armed_q, chg_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         gap_q <= 21'h000000;
         ticks_q <= 11'h000;
         armed_q <= 1'b0;
         chg_q <= 1'b0;
      end else begin
         gap_q <= tick_q ? 21'h000000 : gap_q + 21'h000001;
         if (done_q) begin
            ticks_q <= 11'h000;
         end else if (tick_q) begin
            ticks_q <= ticks_q + 11'h001;
         end
         armed_q <= armed_q | done_q;
         chg_q <= (conv_sel != $past(conv_sel)) || (avg_sel != $past(avg_sel)) || (chg_q && !done_q);
      end
   end

   chk_conv_spacing: assert property (@(posedge clk) disable iff (!rstn)
      (tick_q && armed_q && !chg_q && $stable(conv_sel)) |-> gap_q == limit - 21'h000001)
      else $error("conversion period does not match selected time");
   chk_avg_group: assert property (@(posedge clk) disable iff (!rstn)
      (done_q && $stable(avg_sel)) |-> tick_q && (!armed_q || chg_q || ticks_q == navg - 11'h001))
      else $error("sample period is not conversion time times averaging count");
endmodule

// ### logic/pmrs_div_if.sv
`timescale 1ns/1ps
interface pmrs_div_if;
   logic start;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic done;
   logic [31:0] quotient;
   modport master(output start, output dividend, output divisor, input done, input quotient);
   modport slave(input start, input dividend, input divisor, output done, output quotient);
endinterface

// ### logic/pmrs_divider.sv
`timescale 1ns/1ps
module pmrs_divider (
   input wire logic clk,
   input wire logic rstn,
   pmrs_div_if.slave d
);
   // One quotient bit per cycle; start is ignored while busy
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [5:0] cnt_q, cnt_d;
   logic [15:0] rem_q, rem_d;
   logic [15:0] dvs_q, dvs_d;
   logic [31:0] quo_q, quo_d;
   logic [16:0] trial;
   logic [16:0] diff;

   always_comb begin
      busy_d = busy_q;
      cnt_d = cnt_q;
      rem_d = rem_q;
      dvs_d = dvs_q;
      quo_d = quo_q;
      done_d = 1'b0;
      trial = {rem_q, quo_q[31]};
      diff = trial - {1'b0, dvs_q};
      if (busy_q) begin
         quo_d = {quo_q[30:0], 1'b0};
         if (trial >= {1'b0, dvs_q}) begin
            rem_d = diff[15:0];
            quo_d[0] = 1'b1;
         end else begin
            rem_d = trial[15:0];
         end
         cnt_d = cnt_q + 6'h01;
         if (cnt_q == 6'h1f) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end else if (d.start) begin
         busy_d = 1'b1;
         cnt_d = 6'h00;
         rem_d = 16'h0000;
         dvs_d = d.divisor;
         quo_d = d.dividend;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 6'h00;
         rem_q <= 16'h0000;
         dvs_q <= 16'h0000;
         quo_q <= 32'h00000000;
      end else begin
         busy_q <= busy_d;
         done_q <= done_d;
         cnt_q <= cnt_d;
         rem_q <= rem_d;
         dvs_q <= dvs_d;
         quo_q <= quo_d;
      end
   end

   assign d.done = done_q;
   assign d.quotient = quo_q;

   chk_div_latency: assert property (@(posedge clk) disable iff (!rstn) (d.start && !busy_q) |-> ##33 done_q)
      else $error("divider result not ready 33 cycles after start");
endmodule

// ### logic/pmrs_pkg.sv
package pmrs_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PS_PER_US = 1000000;
   localparam int CYCLES_PER_US_DFLT = PS_PER_US / CLK_PERIOD_PS;
   localparam int CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
   localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
   localparam int CONV_CNT_W = 21;
   localparam int AVG_CNT_W = 11;

   // Result scaling
   localparam int SHUNT_LSB_WIDE_PV = 312500;
   localparam int SHUNT_LSB_NARROW_PV = 78125;
   localparam int BUS_LSB_PV = 195312500;
   localparam int TEMP_LSB_NANO_C = 7812500;
   localparam int CUR_SCALE_SHIFT = 12;
   localparam int POWER_SHIFT = 14;

   // Register map
   localparam logic [5:0] OFS_CONFIG = 6'h00;
   localparam logic [5:0] OFS_ADC_CONFIG = 6'h01;
   localparam logic [5:0] OFS_SHUNT_CAL = 6'h02;
   localparam logic [5:0] OFS_SHUNT = 6'h04;
   localparam logic [5:0] OFS_BUS = 6'h05;
   localparam logic [5:0] OFS_TEMP = 6'h06;
   localparam logic [5:0] OFS_CURRENT = 6'h07;
   localparam logic [5:0] OFS_POWER = 6'h08;
   localparam logic [5:0] OFS_ENERGY = 6'h09;
   localparam logic [5:0] OFS_CHARGE = 6'h0a;
   localparam logic [5:0] OFS_DIE_IDENTITY = 6'h3f;

   // Field positions
   localparam int CFG_SPAN_BIT = 0;
   localparam int CFG_CLEAR_BIT = 1;
   localparam int ADC_CONV_LSB = 0;
   localparam int ADC_AVG_LSB = 3;

   // Reset values
   localparam logic RST_SPAN = 1'b0;
   localparam logic [2:0] RST_CONV_SEL = 3'h5;
   localparam logic [2:0] RST_AVG_SEL = 3'h0;
   localparam logic [15:0] RST_SHUNT_CAL = 16'h1000;

   // Identity, values arbitrary
   localparam logic [11:0] DIE_CODE = 12'h5a5;
   localparam logic [3:0] SILICON_REV = 4'h3;

   typedef enum logic [3:0] {
      ST_COLLECT = 4'b0001,
      ST_DIVIDE = 4'b0010,
      ST_POWER = 4'b0100,
      ST_ACCUM = 4'b1000
   } pmrs_state_t;

   function automatic logic [CONV_CNT_W-1:0] conv_cycles(input logic [2:0] sel, input int cpu);
      conv_cycles = CONV_CNT_W'(CONV_US[sel] * cpu);
   endfunction

   function automatic logic [AVG_CNT_W-1:0] avg_count(input logic [2:0] sel);
      avg_count = AVG_CNT_W'(1) << AVG_SHIFT[sel];
   endfunction

endpackage

// ### logic/pmrs_top.sv
`timescale 1ns/1ps
module pmrs_top #(
   parameter int CYCLES_PER_US = pmrs_pkg::CYCLES_PER_US_DFLT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [5:0] reg_addr,
   input wire logic [39:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [39:0] reg_rdata,
   input wire logic [19:0] shunt_sample,
   input wire logic [19:0] rail_sample,
   input wire logic [15:0] temp_sample,
   output logic shunt_span_select,
   output logic conv_strobe
);
   // Register group
   logic span_q, span_d;
   logic [2:0] conv_sel_q, conv_sel_d;
   logic [2:0] avg_sel_q, avg_sel_d;
   logic [15:0] cal_q, cal_d;
   logic [39:0] rdata_q, rdata_d;
   logic acc_clear;

   // Averaging group
   logic signed [30:0] shunt_sum_q, shunt_sum_d;
   logic signed [30:0] rail_sum_q, rail_sum_d;
   logic signed [30:0] temp_sum_q, temp_sum_d;

   // Result group
   pmrs_pkg::pmrs_state_t state_q, state_d;
   logic [19:0] shunt_res_q, shunt_res_d;
   logic [19:0] rail_res_q, rail_res_d;
   logic [15:0] temp_res_q, temp_res_d;
   logic [19:0] current_q, current_d;
   logic [23:0] power_q, power_d;
   logic [39:0] energy_q, energy_d;
   logic [39:0] charge_q, charge_d;
   logic neg_q, neg_d;
   logic start_q, start_d;
   logic tick_q;

   logic conv_tick;
   logic cycle_done;
   logic [3:0] avg_sh;
   logic signed [30:0] shunt_tot, rail_tot, temp_tot;
   logic [19:0] shunt_mag;
   logic [19:0] cur_mag;
   logic [39:0] pwr_prod;
   logic [25:0] pwr_scaled;
   logic signed [30:0] shunt_avg, rail_avg, temp_avg;

   pmrs_div_if div_bus();

   pmrs_conv_timer #(
      .CYCLES_PER_US(CYCLES_PER_US)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .conv_sel(conv_sel_q),
      .avg_sel(avg_sel_q),
      .conv_tick(conv_tick),
      .cycle_done(cycle_done)
   );

   pmrs_divider u_div (
      .clk(clk),
      .rstn(rstn),
      .d(div_bus.slave)
   );

   function automatic logic signed [30:0] avg_div(input logic signed [30:0] s, input logic [3:0] sh);
      avg_div = s >>> sh;
   endfunction

   function automatic logic [19:0] mag20(input logic [19:0] v);
      mag20 = v[19] ? (20'h00000 - v) : v;
   endfunction

   assign acc_clear = reg_wr && (reg_addr == pmrs_pkg::OFS_CONFIG) && reg_wdata[pmrs_pkg::CFG_CLEAR_BIT];

   always_comb begin
      span_d = span_q;
      conv_sel_d = conv_sel_q;
      avg_sel_d = avg_sel_q;
      cal_d = cal_q;
      rdata_d = 40'h0000000000;
      if (reg_wr) begin
         if (reg_addr == pmrs_pkg::OFS_CONFIG) begin
            span_d = reg_wdata[pmrs_pkg::CFG_SPAN_BIT];
         end else if (reg_addr == pmrs_pkg::OFS_ADC_CONFIG) begin
            conv_sel_d = reg_wdata[pmrs_pkg::ADC_CONV_LSB +: 3];
            avg_sel_d = reg_wdata[pmrs_pkg::ADC_AVG_LSB +: 3];
         end else if (reg_addr == pmrs_pkg::OFS_SHUNT_CAL) begin
            cal_d = reg_wdata[15:0];
         end
      end
      // Unmapped addresses and the clear bit read as zero
      if (reg_rd) begin
         if (reg_addr == pmrs_pkg::OFS_CONFIG) begin
            rdata_d = {39'h0000000000, span_q};
         end else if (reg_addr == pmrs_pkg::OFS_ADC_CONFIG) begin
            rdata_d = {34'h000000000, avg_sel_q, conv_sel_q};
         end else if (reg_addr == pmrs_pkg::OFS_SHUNT_CAL) begin
            rdata_d = {24'h000000, cal_q};
         end else if (reg_addr == pmrs_pkg::OFS_SHUNT) begin
            rdata_d = {20'h00000, shunt_res_q};
         end else if (reg_addr == pmrs_pkg::OFS_BUS) begin
            rdata_d = {20'h00000, rail_res_q};
         end else if (reg_addr == pmrs_pkg::OFS_TEMP) begin
            rdata_d = {24'h000000, temp_res_q};
         end else if (reg_addr == pmrs_pkg::OFS_CURRENT) begin
            rdata_d = {20'h00000, current_q};
         end else if (reg_addr == pmrs_pkg::OFS_POWER) begin
            rdata_d = {16'h0000, power_q};
         end else if (reg_addr == pmrs_pkg::OFS_ENERGY) begin
            rdata_d = energy_q;
         end else if (reg_addr == pmrs_pkg::OFS_CHARGE) begin
            rdata_d = charge_q;
         end else if (reg_addr == pmrs_pkg::OFS_DIE_IDENTITY) begin
            rdata_d = {24'h000000, pmrs_pkg::DIE_CODE, pmrs_pkg::SILICON_REV};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         span_q <= pmrs_pkg::RST_SPAN;
         conv_sel_q <= pmrs_pkg::RST_CONV_SEL;
         avg_sel_q <= pmrs_pkg::RST_AVG_SEL;
         cal_q <= pmrs_pkg::RST_SHUNT_CAL;
         rdata_q <= 40'h0000000000;
      end else begin
         span_q <= span_d;
         conv_sel_q <= conv_sel_d;
         avg_sel_q <= avg_sel_d;
         cal_q <= cal_d;
         rdata_q <= rdata_d;
      end
   end

   // Samples are summed per conversion and scaled once per output period
   always_comb begin
      avg_sh = 4'(pmrs_pkg::AVG_SHIFT[avg_sel_q]);
      shunt_tot = shunt_sum_q + 31'(signed'(shunt_sample));
      rail_tot = rail_sum_q + 31'({1'b0, rail_sample});
      temp_tot = temp_sum_q + 31'(signed'(temp_sample));
      shunt_sum_d = shunt_sum_q;
      rail_sum_d = rail_sum_q;
      temp_sum_d = temp_sum_q;
      if (cycle_done) begin
         shunt_sum_d = 31'h00000000;
         rail_sum_d = 31'h00000000;
         temp_sum_d = 31'h00000000;
      end else if (conv_tick) begin
         shunt_sum_d = shunt_tot;
         rail_sum_d = rail_tot;
         temp_sum_d = temp_tot;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         shunt_sum_q <= 31'h00000000;
         rail_sum_q <= 31'h00000000;
         temp_sum_q <= 31'h00000000;
         tick_q <= 1'b0;
      end else begin
         shunt_sum_q <= shunt_sum_d;
         rail_sum_q <= rail_sum_d;
         temp_sum_q <= temp_sum_d;
         tick_q <= conv_tick;
      end
   end

   // A period that ends while the previous one is still being scaled is skipped
   always_comb begin
      state_d = state_q;
      shunt_res_d = shunt_res_q;
      rail_res_d = rail_res_q;
      temp_res_d = temp_res_q;
      current_d = current_q;
      power_d = power_q;
      energy_d = energy_q;
      charge_d = charge_q;
      neg_d = neg_q;
      start_d = 1'b0;
      shunt_mag = mag20(shunt_res_q);
      cur_mag = mag20(current_q);
      pwr_prod = {20'h00000, cur_mag} * {20'h00000, rail_res_q};
      pwr_scaled = pwr_prod[pmrs_pkg::POWER_SHIFT +: 26];
      shunt_avg = avg_div(shunt_tot, avg_sh);
      rail_avg = avg_div(rail_tot, avg_sh);
      temp_avg = avg_div(temp_tot, avg_sh);
      case (state_q)
         pmrs_pkg::ST_COLLECT: begin
            if (cycle_done) begin
               shunt_res_d = shunt_avg[19:0];
               rail_res_d = rail_avg[19:0];
               temp_res_d = temp_avg[15:0];
               if (cal_q == 16'h0000) begin
                  current_d = 20'h00000;
                  state_d = pmrs_pkg::ST_POWER;
               end else begin
                  start_d = 1'b1;
                  state_d = pmrs_pkg::ST_DIVIDE;
               end
            end
         end
         pmrs_pkg::ST_DIVIDE: begin
            neg_d = shunt_res_q[19];
            if (div_bus.done) begin
               // Saturate the magnitude, then restore the sign
               if (div_bus.quotient > 32'h0007ffff) begin
                  current_d = neg_q ? 20'h80000 : 20'h7ffff;
               end else begin
                  current_d = neg_q ? (20'h00000 - div_bus.quotient[19:0]) : div_bus.quotient[19:0];
               end
               state_d = pmrs_pkg::ST_POWER;
            end
         end
         pmrs_pkg::ST_POWER: begin
            power_d = (pwr_scaled > 26'h0ffffff) ? 24'hffffff : pwr_scaled[23:0];
            state_d = pmrs_pkg::ST_ACCUM;
         end
         pmrs_pkg::ST_ACCUM: begin
            energy_d = energy_q + {16'h0000, power_q};
            charge_d = charge_q + {{20{current_q[19]}}, current_q};
            state_d = pmrs_pkg::ST_COLLECT;
         end
         default: begin
            state_d = pmrs_pkg::ST_COLLECT;
         end
      endcase
      // Clear beats a same-cycle accumulation so software sees exactly zero
      if (acc_clear) begin
         energy_d = 40'h0000000000;
         charge_d = 40'h0000000000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= pmrs_pkg::ST_COLLECT;
         shunt_res_q <= 20'h00000;
         rail_res_q <= 20'h00000;
         temp_res_q <= 16'h0000;
         current_q <= 20'h00000;
         power_q <= 24'h000000;
         energy_q <= 40'h0000000000;
         charge_q <= 40'h0000000000;
         neg_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         shunt_res_q <= shunt_res_d;
         rail_res_q <= rail_res_d;
         temp_res_q <= temp_res_d;
         current_q <= current_d;
         power_q <= power_d;
         energy_q <= energy_d;
         charge_q <= charge_d;
         neg_q <= neg_d;
         start_q <= start_d;
      end
   end

   // Dividend is the shunt magnitude scaled so the calibration divides it into current counts
   assign div_bus.start = start_q;
   assign div_bus.dividend = {12'h000, shunt_mag} << pmrs_pkg::CUR_SCALE_SHIFT;
   assign div_bus.divisor = cal_q;

   assign reg_rdata = rdata_q;
   assign shunt_span_select = span_q;
   assign conv_strobe = tick_q;

   chk_id_readback: assert property (@(posedge clk) disable iff (!rstn)
      (reg_rd && reg_addr == pmrs_pkg::OFS_DIE_IDENTITY) |=> reg_rdata == {24'h000000, 16'h5a53})
      else $error("identity register read wrong value");
   chk_span_write: assert property (@(posedge clk) disable iff (!rstn)
      (reg_wr && reg_addr == pmrs_pkg::OFS_CONFIG) |=> shunt_span_select == $past(reg_wdata[0]))
      else $error("span select did not follow config write");
   chk_cal_zero: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == pmrs_pkg::ST_COLLECT && cycle_done && cal_q == 16'h0000) |=> current_q == 20'h00000)
      else $error("current not zero with zero calibration");
   chk_current_wait: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == pmrs_pkg::ST_COLLECT && cycle_done && cal_q != 16'h0000) |-> ##[30:40] state_q == pmrs_pkg::ST_POWER)
      else $error("current computation did not finish in time");
   chk_clear_accum: assert property (@(posedge clk) disable iff (!rstn)
      (reg_wr && reg_addr == pmrs_pkg::OFS_CONFIG && reg_wdata[1]) |=> (energy_q == 40'h0 && charge_q == 40'h0))
      else $error("accumulators not cleared");
   chk_energy_add: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == pmrs_pkg::ST_ACCUM && !acc_clear) |=> energy_q == $past(energy_q) + {16'h0000, $past(power_q)})
      else $error("energy did not add power");
   chk_charge_add: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == pmrs_pkg::ST_ACCUM && !acc_clear) |=> charge_q == $past(charge_q) + {{20{$past(current_q[19])}}, $past(current_q)})
      else $error("charge did not add signed current");
   chk_power_zero: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == pmrs_pkg::ST_POWER && (current_q == 20'h00000 || rail_res_q == 20'h00000)) |=> power_q == 24'h000000)
      else $error("power nonzero with zero current or rail");
endmodule

// ### tb/pmrs_host_model.sv
`timescale 1ns/1ps
module pmrs_host_model #(
   parameter logic [15:0] CAL_WIDE = 16'h0c35
) (
   input wire logic span,
   output logic [15:0] cal_value
);
   // Wide-span count from a rounded current LSB and the shunt value
   // Narrow span needs four times the count to keep the current scale
   assign cal_value = span ? {CAL_WIDE[13:0], 2'b00} : CAL_WIDE;
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [39:0] reg_wdata = 40'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [39:0] reg_rdata;
   logic [19:0] shunt_sample = 20'h0;
   logic [19:0] rail_sample = 20'h0;
   logic [15:0] temp_sample = 16'h0;
   logic span;
   logic conv_strobe;
   logic [15:0] cal;
   logic [31:0] seed = 32'd28188;
   int miscompares = 0;
   int samples_checked = 0;
   int conv_tab [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
   always #2 clk = ~clk;
   // One cycle per microsecond keeps the slowest period at 4120 cycles
   pmrs_top #(.CYCLES_PER_US(1)) pmrs_top_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .shunt_sample(shunt_sample), .rail_sample(rail_sample), .temp_sample(temp_sample),
      .shunt_span_select(span), .conv_strobe(conv_strobe));
   pmrs_host_model pmrs_host_model_i (.span(span), .cal_value(cal));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [19:0] exp_cur(input logic [19:0] s, input logic [15:0] c);
      longint q;
      if (c == 16'h0) return 20'h0;
      q = longint'($signed(s));
      if (q < 0) q = -q;
      q = (q * 4096) / c;
      if (s[19]) q = -q;
      if (q > 524287) q = 524287;
      if (q < -524288) q = -524288;
      return q[19:0];
   endfunction
   function automatic logic [23:0] exp_pow(input logic [19:0] cu, input logic [19:0] r);
      longint a;
      a = longint'($signed(cu));
      if (a < 0) a = -a;
      a = (a * r) >> 14;
      if (a > 64'hffffff) a = 64'hffffff;
      return a[23:0];
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [39:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [39:0] exp);
      logic [39:0] d;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk(d, exp);
      @(posedge clk);
   endtask
   // Returns the edges counted until a strobe cycle has been seen
   task automatic wait_strobe(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (conv_strobe !== 1'b1 && n < 6000);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #240000;
      miscompares++;
      finish_test();
   end
   initial begin
      logic [19:0] s, r, cu;
      logic [15:0] t, calv;
      logic [23:0] pw;
      logic [39:0] e_acc, c_acc;
      int n;
      longint ss, rs, ts;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rchk(pmrs_pkg::OFS_DIE_IDENTITY, {24'h0, pmrs_pkg::DIE_CODE, pmrs_pkg::SILICON_REV});
      wr(pmrs_pkg::OFS_DIE_IDENTITY, 40'h0);
      rchk(pmrs_pkg::OFS_DIE_IDENTITY, {24'h0, pmrs_pkg::DIE_CODE, pmrs_pkg::SILICON_REV});
      rchk(6'h3e, 40'h0);
      rchk(pmrs_pkg::OFS_ADC_CONFIG, 40'h05);
      rchk(pmrs_pkg::OFS_ENERGY, 40'h0);
      $display("test reset_and_identity done");
      for (int sp = 0; sp < 2; sp++) begin
         wr(pmrs_pkg::OFS_CONFIG, 40'(sp));
         chk({39'h0, span}, 40'(sp));
         wr(pmrs_pkg::OFS_SHUNT_CAL, {24'h0, cal});
         calv = cal;
         wr(pmrs_pkg::OFS_ADC_CONFIG, 40'h01);
         wait_strobe(n);
         repeat (40) @(posedge clk);
         // Clear lands well away from the next accumulation
         wr(pmrs_pkg::OFS_CONFIG, 40'(sp) | 40'h2);
         e_acc = 40'h0;
         c_acc = 40'h0;
         for (int i = 0; i < 6; i++) begin
            s = (i == 0) ? 20'h80000 : 20'(rnd());
            r = (i == 0) ? 20'hfffff : 20'(rnd());
            t = (i == 1) ? 16'h8000 : 16'(rnd());
            shunt_sample <= s;
            rail_sample <= r;
            temp_sample <= t;
            wait_strobe(n);
            repeat (38) @(posedge clk);
            cu = exp_cur(s, calv);
            pw = exp_pow(cu, r);
            e_acc = e_acc + {16'h0, pw};
            c_acc = c_acc + {{20{cu[19]}}, cu};
            rchk(pmrs_pkg::OFS_SHUNT, {20'h0, s});
            rchk(pmrs_pkg::OFS_BUS, {20'h0, r});
            rchk(pmrs_pkg::OFS_TEMP, {24'h0, t});
            rchk(pmrs_pkg::OFS_CURRENT, {20'h0, cu});
            rchk(pmrs_pkg::OFS_POWER, {16'h0, pw});
            rchk(pmrs_pkg::OFS_ENERGY, e_acc);
            rchk(pmrs_pkg::OFS_CHARGE, c_acc);
            if (i == 3) begin
               wr(pmrs_pkg::OFS_SHUNT_CAL, 40'h0);
               calv = 16'h0;
            end
         end
         wr(pmrs_pkg::OFS_CONFIG, 40'(sp) | 40'h2);
         rchk(pmrs_pkg::OFS_ENERGY, 40'h0);
         rchk(pmrs_pkg::OFS_CHARGE, 40'h0);
         rchk(pmrs_pkg::OFS_CONFIG, 40'(sp));
      end
      $display("test results_and_accumulators done");
      // Reset restarts the averaging count, so the fourth tick closes the first period
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({39'h0, span}, 40'h0);
      wr(pmrs_pkg::OFS_ADC_CONFIG, 40'h08);
      ss = 0;
      rs = 0;
      ts = 0;
      for (int j = 0; j < 4; j++) begin
         s = 20'(rnd());
         r = 20'(rnd());
         t = 16'(rnd());
         ss += longint'($signed(s));
         rs += longint'(r);
         ts += longint'($signed(t));
         shunt_sample <= s;
         rail_sample <= r;
         temp_sample <= t;
         wait_strobe(n);
         if (j < 3) rchk(pmrs_pkg::OFS_SHUNT, 40'h0);
      end
      rchk(pmrs_pkg::OFS_SHUNT, {20'h0, 20'(ss >>> 2)});
      rchk(pmrs_pkg::OFS_BUS, {20'h0, 20'(rs >>> 2)});
      rchk(pmrs_pkg::OFS_TEMP, {24'h0, 16'(ts >>> 2)});
      $display("test reset_and_averaging done");
      for (int k = 0; k < 8; k++) begin
         wr(pmrs_pkg::OFS_ADC_CONFIG, 40'(k));
         wait_strobe(n);
         wait_strobe(n);
         wait_strobe(n);
         chk(40'(n), 40'(conv_tab[k]));
      end
      $display("test conversion_times done");
      finish_test();
   end
endmodule
